// [design/timer_chain_defs.svh]
// Register map, field positions and reset values of the timer chain.
// Assumes a byte-addressed 32-bit classic Wishbone slave port.
`ifndef TIMER_CHAIN_DEFS_SVH
`define TIMER_CHAIN_DEFS_SVH

// ==========================================================
// Per-timer registers, at timer index times the stride.
`define TIX_BIT 5
`define ROFF_MASK 8'h1F
`define R_CTL 8'h00
`define R_LOAD 8'h04
`define R_MATCH 8'h08
`define R_PRE 8'h0C
`define R_CNT 8'h10
`define R_CAP 8'h14

// ==========================================================
// Shared registers.
`define GLB_BASE 8'h40
`define R_SYNC 8'h40
`define R_PROPS 8'h44
`define R_ISR 8'h48
`define R_IMR 8'h4C

// ==========================================================
// Control fields and constants.
`define CTL_EN 0
`define CTL_UP 1
`define CTL_WOT 2
`define CTL_MODE_LO 4
`define CTL_MODE_HI 6
`define PROPS_VAL 32'h0000_0000
`define LOAD_RST 16'hFFFF
`define ZERO16 16'h0000
`define ONE16 16'h0001

`endif

// [design/timer_chain_pkg.sv]
// Types shared by the timer chain.
// Assumes nothing of its surroundings.
package timer_chain_pkg;
   typedef enum logic [2:0] {
      MODE_ONESHOT,
      MODE_PERIODIC,
      MODE_RTC,
      MODE_EDGE_CNT,
      MODE_EDGE_TIME,
      MODE_PWM
   } mode_t;
endpackage

// [design/timer_chain.sv]
// Two chained 16-bit timers with sync, capture and PWM behind Wishbone.
// Assumes edge_i is synchronous to clk_i and one cycle wide per edge.
`timescale 1ns/1ps
`default_nettype none
`include "timer_chain_defs.svh"

module timer_chain (
   input wire logic clk_i,             // System clock.
   input wire logic rst_i,             // Synchronous reset, active high.
   input wire logic ce_i,              // Clock enable; low freezes all state.
   input wire logic wb_cyc_i,          // Wishbone cycle.
   input wire logic wb_stb_i,          // Wishbone strobe.
   input wire logic wb_we_i,           // Wishbone write enable.
   input wire logic [7:0] wb_adr_i,    // Byte address.
   input wire logic [3:0] wb_sel_i,    // Byte enables.
   input wire logic [31:0] wb_dat_i,   // Write data.
   output logic [31:0] wb_dat_o,       // Read data.
   output logic wb_ack_o,              // Acknowledge.
   input wire logic [1:0] edge_i,      // Input edge events per timer.
   output logic [1:0] pwm_o,           // PWM outputs per timer.
   output logic irq_o                  // Level interrupt.
);
   import timer_chain_pkg::*;

   // ==========================================================
   // Helpers.

   // Byte-lane merge of a 16-bit register.
   function automatic logic [15:0] merge16(input logic [15:0] o, input logic [31:0] d,
                                           input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
   endfunction

   // Event-driven modes, which misbehave on sync and register writes.
   function automatic logic is_ev(input mode_t m);
      is_ev = (m == MODE_RTC) || (m == MODE_EDGE_CNT);
   endfunction

   // Modes able to take part in a daisy chain.
   function automatic logic is_chain(input mode_t m);
      is_chain = (m == MODE_ONESHOT) || (m == MODE_PERIODIC);
   endfunction

   // ==========================================================
   // State.
   logic ack_r;
   logic [31:0] rdat;
   logic [15:0] cnt_r [2];
   logic [15:0] load_r [2];
   logic [15:0] match_r [2];
   logic [15:0] pre_r [2];
   logic [15:0] pcnt_r [2];
   logic [15:0] cap_r [2];
   mode_t mode_r [2];
   logic [1:0] en_r, up_r, wot_r, run_r, sync_r;
   logic [5:0] isr_r, imr_r;
   logic [15:0] cnt_nxt [2];
   logic [15:0] pcnt_nxt [2];
   logic [1:0] en_nxt, run_nxt, pwm_nxt, tmo, mat, cap;

   // ==========================================================
   // Bus decode.  Ack follows the request by a cycle; writes land with it.
   wire req = wb_cyc_i & wb_stb_i & ~ack_r;
   wire wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
   wire in_tmr = wb_adr_i < `GLB_BASE;
   wire [7:0] roff = wb_adr_i & `ROFF_MASK;
   wire tix = wb_adr_i[`TIX_BIT];
   wire [1:0] hit = {wr & in_tmr & tix, wr & in_tmr & ~tix};
   wire [1:0] wr_ctl = hit & {2{(roff == `R_CTL) && wb_sel_i[0]}};
   wire [1:0] wr_load = hit & {2{roff == `R_LOAD}};
   wire [1:0] wr_match = hit & {2{roff == `R_MATCH}};
   wire [1:0] wr_pre = hit & {2{roff == `R_PRE}};
   wire wr_sync = wr & (wb_adr_i == `R_SYNC) & wb_sel_i[0];
   wire wr_isr = wr & (wb_adr_i == `R_ISR) & wb_sel_i[0];
   wire wr_imr = wr & (wb_adr_i == `R_IMR) & wb_sel_i[0];

   // Mode classes and the chain trigger into the second timer.
   wire [1:0] evm = {is_ev(mode_r[1]), is_ev(mode_r[0])};
   // A PWM predecessor gives no trigger; the pair must both chain.
   wire [1:0] chain_in = {tmo[0] & is_chain(mode_r[0]) & is_chain(mode_r[1]), 1'b0};

   // Sync acts only on bits that newly rise, since only a software write clears them.
   wire [1:0] sync_new = wr_sync ? (wb_dat_i[1:0] & ~sync_r) : 2'h0;
   // One event-mode timer among the selected ones cancels the lot.
   wire sync_block = |(sync_new & evm);
   wire [1:0] fire = sync_block ? 2'h0 : sync_new;

   // Match or prescale writes nudge event-mode counters.
   wire [1:0] bump = (wr_match | wr_pre) & en_r & evm;

   // Status clear mask; a new event in the same cycle wins.
   wire [5:0] isr_clr = wr_isr ? wb_dat_i[5:0] : 6'h00;
   wire [5:0] isr_nxt = (isr_r & ~isr_clr) | {cap, mat, tmo};

   // ==========================================================
   // Counting for both timers.  The load value is not screened;
   // software keeps 0xFFFF out of it in edge-time count-up.
   always_comb begin
      for (int t = 0; t < 2; t++) begin
         cnt_nxt[t] = cnt_r[t];
         pcnt_nxt[t] = pcnt_r[t];
         en_nxt[t] = en_r[t];
         run_nxt[t] = run_r[t];
         pwm_nxt[t] = pwm_o[t];
         tmo[t] = 1'b0;
         mat[t] = 1'b0;
         cap[t] = 1'b0;
         if (!en_r[t]) begin
            run_nxt[t] = 1'b0;
         end else if (bump[t]) begin
            cnt_nxt[t] = up_r[t] ? cnt_r[t] + `ONE16 : cnt_r[t] - `ONE16;
         end else if (!run_r[t]) begin
            // PWM ignores the wait; otherwise wait for the trigger.
            if (!wot_r[t] || mode_r[t] == MODE_PWM || chain_in[t]) begin
               run_nxt[t] = 1'b1;
            end
         end else begin
            pcnt_nxt[t] = (pcnt_r[t] == pre_r[t]) ? `ZERO16 : pcnt_r[t] + `ONE16;
            case (mode_r[t])
               MODE_EDGE_CNT: begin
                  if (edge_i[t]) begin
                     if (cnt_r[t] == match_r[t]) begin
                        // The wrap costs an edge of its own.
                        cnt_nxt[t] = up_r[t] ? `ZERO16 : load_r[t];
                     end else begin
                        cnt_nxt[t] = up_r[t] ? cnt_r[t] + `ONE16 : cnt_r[t] - `ONE16;
                     end
                     mat[t] = cnt_nxt[t] == match_r[t];
                  end
               end
               MODE_EDGE_TIME: begin
                  cap[t] = edge_i[t];
                  if (pcnt_r[t] == pre_r[t]) begin
                     if (up_r[t]) begin
                        cnt_nxt[t] = (cnt_r[t] == load_r[t]) ? `ZERO16 : cnt_r[t] + `ONE16;
                     end else begin
                        cnt_nxt[t] = (cnt_r[t] == `ZERO16) ? load_r[t] : cnt_r[t] - `ONE16;
                     end
                  end
               end
               MODE_RTC: begin
                  if (pcnt_r[t] == pre_r[t]) begin
                     cnt_nxt[t] = cnt_r[t] + `ONE16;
                     mat[t] = cnt_nxt[t] == match_r[t];
                  end
               end
               MODE_PWM: begin
                  if (pcnt_r[t] == pre_r[t]) begin
                     cnt_nxt[t] = (cnt_r[t] == `ZERO16) ? load_r[t] : cnt_r[t] - `ONE16;
                  end
                  pwm_nxt[t] = cnt_r[t] > match_r[t];
               end
               default: begin
                  if (pcnt_r[t] == pre_r[t]) begin
                     if (up_r[t] ? (cnt_r[t] == load_r[t]) : (cnt_r[t] == `ZERO16)) begin
                        tmo[t] = 1'b1;
                        cnt_nxt[t] = up_r[t] ? `ZERO16 : load_r[t];
                        if (mode_r[t] == MODE_ONESHOT) begin
                           run_nxt[t] = 1'b0;
                           en_nxt[t] = 1'b0;
                        end
                     end else begin
                        cnt_nxt[t] = up_r[t] ? cnt_r[t] + `ONE16 : cnt_r[t] - `ONE16;
                     end
                  end
               end
            endcase
         end
         // Software enable; a fresh enable loads the start value.
         if (wr_ctl[t]) begin
            en_nxt[t] = wb_dat_i[`CTL_EN];
            if (!en_nxt[t]) begin
               run_nxt[t] = 1'b0;
            end else if (!en_r[t]) begin
               cnt_nxt[t] = wb_dat_i[`CTL_UP] ? `ZERO16 : load_r[t];
               pcnt_nxt[t] = `ZERO16;
            end
         end
         // Sync restarts the selected timers together.
         if (fire[t]) begin
            cnt_nxt[t] = up_r[t] ? `ZERO16 : load_r[t];
            pcnt_nxt[t] = `ZERO16;
         end
      end
   end

   // ==========================================================
   // Read data selection.
   always_comb begin
      rdat = 32'h0000_0000;
      if (in_tmr) begin
         if (roff == `R_CTL) begin
            rdat = {25'h0, mode_r[tix], 1'b0, wot_r[tix], up_r[tix], en_r[tix]};
         end else if (roff == `R_LOAD) begin
            rdat = {16'h0, load_r[tix]};
         end else if (roff == `R_MATCH) begin
            rdat = {16'h0, match_r[tix]};
         end else if (roff == `R_PRE) begin
            rdat = {16'h0, pre_r[tix]};
         end else if (roff == `R_CNT) begin
            rdat = {16'h0, cnt_r[tix]};
         end else if (roff == `R_CAP) begin
            rdat = {16'h0, cap_r[tix]};
         end
      end else if (wb_adr_i == `R_SYNC) begin
         rdat = {30'h0, sync_r};
      end else if (wb_adr_i == `R_PROPS) begin
         rdat = `PROPS_VAL; // Wide timers still report the narrow class.
      end else if (wb_adr_i == `R_ISR) begin
         rdat = {26'h0, isr_r};
      end else if (wb_adr_i == `R_IMR) begin
         rdat = {26'h0, imr_r};
      end
   end

   // ==========================================================
   // Bus handshake, shared registers and interrupt.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         sync_r <= 2'h0;
         isr_r <= 6'h00;
         imr_r <= 6'h00;
         irq_o <= 1'b0;
      end else if (ce_i) begin
         ack_r <= req;
         wb_ack_o <= req;
         if (req) begin
            wb_dat_o <= rdat;
         end
         if (wr_sync) begin
            sync_r <= wb_dat_i[1:0]; // Held until software writes zero.
         end
         if (wr_imr) begin
            imr_r <= wb_dat_i[5:0];
         end
         isr_r <= isr_nxt;
         irq_o <= |(isr_r & imr_r);
      end
   end

   // Per-timer registers.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int t = 0; t < 2; t++) begin
            cnt_r[t] <= `ZERO16;
            pcnt_r[t] <= `ZERO16;
            load_r[t] <= `LOAD_RST;
            match_r[t] <= `ZERO16;
            pre_r[t] <= `ZERO16;
            cap_r[t] <= `ZERO16;
            mode_r[t] <= MODE_ONESHOT;
         end
         en_r <= 2'h0;
         up_r <= 2'h0;
         wot_r <= 2'h0;
         run_r <= 2'h0;
         pwm_o <= 2'h0;
      end else if (ce_i) begin
         for (int t = 0; t < 2; t++) begin
            cnt_r[t] <= cnt_nxt[t];
            pcnt_r[t] <= pcnt_nxt[t];
            if (cap[t]) begin
               cap_r[t] <= cnt_r[t];
            end
            if (wr_load[t]) begin
               load_r[t] <= merge16(load_r[t], wb_dat_i, wb_sel_i);
            end
            if (wr_match[t]) begin
               match_r[t] <= merge16(match_r[t], wb_dat_i, wb_sel_i);
            end
            if (wr_pre[t]) begin
               pre_r[t] <= merge16(pre_r[t], wb_dat_i, wb_sel_i);
            end
            if (wr_ctl[t]) begin
               up_r[t] <= wb_dat_i[`CTL_UP];
               wot_r[t] <= wb_dat_i[`CTL_WOT];
               mode_r[t] <= mode_t'(wb_dat_i[`CTL_MODE_HI:`CTL_MODE_LO]);
            end
         end
         en_r <= en_nxt;
         run_r <= run_nxt;
         pwm_o <= pwm_nxt;
      end
   end

   // ==========================================================
   // Checks.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_sync_sticky;
      !wr_sync |=> $stable(sync_r);
   endproperty
   a_sync_sticky: assert property (p_sync_sticky) else $error("sync bits changed alone");

   property p_props_zero;
      (ce_i && req && !wb_we_i && wb_adr_i == `R_PROPS) |=> wb_ack_o && wb_dat_o == `PROPS_VAL;
   endproperty
   a_props_zero: assert property (p_props_zero) else $error("properties not zero");

   property p_pwm_go;
      (ce_i && en_r[1] && !run_r[1] && mode_r[1] == MODE_PWM && !wr_ctl[1] && !bump[1])
         |=> run_r[1];
   endproperty
   a_pwm_go: assert property (p_pwm_go) else $error("PWM timer waited");

   property p_pwm_no_trig;
      (mode_r[0] == MODE_PWM) |-> !chain_in[1] ##1 (mode_r[0] != MODE_PWM || !chain_in[1]);
   endproperty
   a_pwm_no_trig: assert property (p_pwm_no_trig) else $error("PWM gave a trigger");

   property p_chain_hold;
      (en_r[1] && wot_r[1] && is_chain(mode_r[1]) && !run_r[1] && !chain_in[1]) |=> !run_r[1];
   endproperty
   a_chain_hold: assert property (p_chain_hold) else $error("waiting timer started");

   property p_chain_go;
      (ce_i && en_r[1] && !run_r[1] && chain_in[1] && !wr_ctl[1] && !bump[1]) |=> run_r[1];
   endproperty
   a_chain_go: assert property (p_chain_go) else $error("chain trigger lost");

   property p_sync_block;
      (ce_i && wr_sync && |(wb_dat_i[1:0] & ~sync_r & evm)) |-> fire == 2'h0;
   endproperty
   a_sync_block: assert property (p_sync_block) else $error("blocked sync fired");

   property p_bump;
      (ce_i && bump[1] && up_r[1] && !fire[1] && !wr_ctl[1]) |=>
         cnt_r[1] == $past(cnt_r[1]) + `ONE16;
   endproperty
   a_bump: assert property (p_bump) else $error("write did not step counter");

   property p_edge_wrap;
      (ce_i && run_r[0] && en_r[0] && mode_r[0] == MODE_EDGE_CNT && up_r[0] && edge_i[0]
         && cnt_r[0] == match_r[0] && !bump[0] && !wr_ctl[0]) |=> cnt_r[0] == `ZERO16;
   endproperty
   a_edge_wrap: assert property (p_edge_wrap) else $error("edge wrap missed");

   property p_ack;
      (ce_i && req) |=> wb_ack_o ##1 (!wb_ack_o || !ce_i);
   endproperty
   a_ack: assert property (p_ack) else $error("ack timing wrong");

endmodule
`default_nettype wire

// [verif/timer_chain_tb_top.sv]
// Self-checking bench for the two-timer chain block with its Wishbone port.
// Assumes the design files compile first and that the bench alone drives every input.
`timescale 1ns/1ps
`default_nettype none
`include "timer_chain_defs.svh"

module general_purpose_timer_chain_sync_tb_top;
   typedef struct {logic rd; logic [31:0] exp; logic [31:0] msk;} note_t;
   logic clk_i;
   logic rst_i;
   logic ce;
   logic cyc;
   logic stb;
   logic we;
   logic [7:0] adr;
   logic [31:0] dat;
   logic [31:0] rdat;
   logic ack;
   logic irq;
   logic [1:0] edg;
   logic [1:0] pwm;
   logic [15:0] lfsr = 16'h005D;
   int num_errors = 0;
   int tests_run = 0;
   note_t notes[$];
   note_t cur;

   // ==========================================
   // Clock and device.
   initial clk_i = 1'b0;
   always #2 clk_i = ~clk_i;

   timer_chain u_timer_chain (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .edge_i(edg), .pwm_o(pwm), .irq_o(irq)
   );

   // ==========================================
   // Helpers.
   function automatic logic [15:0] next_rand(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One classic cycle; the request is held until ack is sampled high, then released.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] e, input logic [31:0] m);
      notes.push_back('{!w, e, m});
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      // Only the watchdog ends a wait that never sees ack.
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 32'h0, 32'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFF_FFFF);
      bus(1'b0, a, 32'h0, e, m);
   endtask

   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge clk_i);
         edg[0] <= 1'b1;
         @(posedge clk_i);
         edg[0] <= 1'b0;
      end
      repeat (3) @(posedge clk_i);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Read answers are matched against the oldest note; writes carry no check.
   always @(posedge clk_i) begin
      if (ack === 1'b1) begin
         if (notes.size() == 0) begin
            cmp(32'h1, 32'h0);
         end else begin
            cur = notes.pop_front();
            if (cur.rd) cmp(rdat & cur.msk, cur.exp);
         end
      end
   end

   // Watchdog sized well past the few hundred cycles the sequence needs.
   initial begin
      #200000;
      num_errors++;
      wrap_up();
   end

   // ==========================================
   // Main sequence.
   initial begin
      ce = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      dat = 32'h0;
      edg = 2'h0;
      rst_i = 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`R_LOAD, 32'h0000_FFFF);
      rd(`R_PROPS, 32'h0);
      wr(8'h18, {16'h0, lfsr});
      rd(8'h18, 32'h0);
      done("reset");
      // Edge-count up with match two: the second match needs one edge more.
      wr(`R_MATCH, 32'h2);
      wr(`R_IMR, 32'h4);
      wr(`R_CTL, 32'h33);
      idle(3);
      pulse(2);
      rd(`R_CNT, 32'h2);
      rd(`R_ISR, 32'h4, 32'h4);
      idle(2);
      cmp({31'h0, irq}, 32'h1);
      wr(`R_ISR, 32'h4);
      idle(2);
      cmp({31'h0, irq}, 32'h0);
      pulse(1);
      rd(`R_CNT, 32'h0);
      pulse(1);
      rd(`R_ISR, 32'h0, 32'h4);
      pulse(1);
      rd(`R_ISR, 32'h4, 32'h4);
      // An edge while the clock enable is low must leave the count alone.
      ce <= 1'b0;
      pulse(1);
      ce <= 1'b1;
      rd(`R_CNT, 32'h2);
      done("edge match");
      // Match and prescale writes step the count, up then down.
      wr(`R_PRE, 32'h0);
      lfsr = next_rand(lfsr);
      wr(`R_MATCH, {16'h0, lfsr});
      rd(`R_CNT, 32'h4);
      wr(`R_CTL, 32'h0);
      wr(`R_CTL, 32'h31);
      idle(3);
      wr(`R_PRE, 32'h0);
      rd(`R_CNT, 32'hFFFE);
      wr(`R_SYNC, 32'h1);
      rd(`R_CNT, 32'hFFFE);
      rd(`R_SYNC, 32'h1);
      wr(`R_SYNC, 32'h0);
      rd(`R_SYNC, 32'h0);
      // RTC with the slowest prescale, so only the write moves the count.
      wr(`R_CTL, 32'h0);
      wr(`R_PRE, 32'hFFFF);
      wr(`R_CTL, 32'h23);
      idle(3);
      lfsr = next_rand(lfsr);
      wr(`R_MATCH, {16'h0, lfsr});
      rd(`R_CNT, 32'h1);
      wr(`R_SYNC, 32'h1);
      rd(`R_CNT, 32'h1);
      wr(`R_SYNC, 32'h0);
      done("write step and sync");
      // Edge-time capture with the interrupt masked off.
      wr(`R_CTL, 32'h0);
      wr(`R_LOAD, 32'h1000); // Load stays below all ones in this mode.
      wr(`R_PRE, 32'h0);
      wr(`R_IMR, 32'h0);
      wr(`R_ISR, 32'h3F);
      wr(`R_CTL, 32'h43);
      idle(3);
      pulse(1);
      rd(`R_ISR, 32'h10, 32'h10);
      rd(`R_CAP, 32'h3);
      cmp({31'h0, irq}, 32'h0);
      done("edge time");
      // Valid chain: the second timer holds until the first times out.
      wr(`R_CTL, 32'h0);
      wr(`R_ISR, 32'h3F);
      wr(`R_PRE, 32'h0);
      wr(`R_LOAD, 32'h14);
      wr(8'h24, 32'h5);
      wr(8'h2C, 32'h0);
      wr(8'h20, 32'h5);
      idle(60);
      rd(`R_ISR, 32'h0, 32'h2);
      rd(8'h30, 32'h5);
      wr(`R_CTL, 32'h11);
      idle(100);
      rd(`R_ISR, 32'h3, 32'h3);
      wr(`R_IMR, 32'h3);
      idle(2);
      cmp({31'h0, irq}, 32'h1);
      // A periodic timer is reloaded by a fresh sync bit, not by a repeated one.
      wr(`R_SYNC, 32'h1);
      rd(`R_CNT, 32'h13);
      wr(`R_SYNC, 32'h1);
      rd(`R_CNT, 32'hD);
      wr(`R_SYNC, 32'h0);
      done("chain");
      // A PWM predecessor never wakes a waiting one-shot.
      wr(`R_CTL, 32'h0);
      wr(8'h20, 32'h0);
      wr(`R_ISR, 32'h3F);
      wr(8'h20, 32'h5);
      wr(`R_CTL, 32'h51);
      idle(100);
      rd(`R_ISR, 32'h0, 32'h2);
      rd(8'h30, 32'h5);
      // A waiting PWM timer runs at once.
      wr(8'h20, 32'h0);
      wr(8'h24, 32'h100);
      wr(8'h28, 32'h2);
      wr(8'h20, 32'h55);
      idle(10);
      cmp({31'h0, pwm[1]}, 32'h1);
      done("pwm chain");
      wrap_up();
   end
endmodule
`default_nettype wire
